/* src/tdcas_pkg.sv */
// constants, word formats and carrier types for the tdc acquisition sequencer
// assumes a 16-bit register port with byte offsets and a 125 MHz mclk
package tdcas_pkg;
	localparam int CLK_PERIOD_NS = 8;
	localparam int CONV_TIME_NS = 1200;
	localparam int CONV_CYCLES = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int NUM_CH = 32;
	localparam int BUF_AW = 11;
	localparam int BUF_DEPTH = 2048;
	localparam int FIFO_DEPTH = 32;
	localparam logic [10:0] EVT_WORDS = 11'h022;

	localparam logic [15:0] ADR_BUF_DATA = 16'h0000;
	localparam logic [15:0] ADR_BC_BASE = 16'h1004;
	localparam logic [15:0] ADR_INT_LEVEL = 16'h100a;
	localparam logic [15:0] ADR_INT_VECTOR = 16'h100c;
	localparam logic [15:0] ADR_STATUS = 16'h100e;
	localparam logic [15:0] ADR_EVT_COUNT = 16'h1024;
	localparam logic [15:0] ADR_READ_ADV = 16'h1028;
	localparam logic [15:0] ADR_BS2_SET = 16'h1032;
	localparam logic [15:0] ADR_BS2_CLR = 16'h1034;
	localparam logic [15:0] ADR_W_TEST_ADDR = 16'h1036;
	localparam logic [15:0] ADR_TEST_HIGH = 16'h1038;
	localparam logic [15:0] ADR_TEST_LOW = 16'h103a;
	localparam logic [15:0] ADR_TEST_EVENT = 16'h103e;
	localparam logic [15:0] ADR_EVC_RESET = 16'h1040;
	localparam logic [15:0] ADR_R_TEST_ADDR = 16'h1064;
	localparam logic [15:0] ADR_SW_COMM = 16'h1068;
	localparam logic [15:0] ADR_THR_BASE = 16'h1080;
	localparam logic [15:0] ADR_THR_MASK = 16'hffc0;

	localparam int BS2_MEMTEST = 0;
	localparam int BS2_OVF_DIS = 3;
	localparam int BS2_ZERO_DIS = 4;
	localparam int BS2_TESTACQ = 6;
	localparam int BS2_COMMON_STOP = 10;
	localparam int BS2_EMPTY_EN = 12;
	localparam int BS2_ALL_TRIG = 14;

	localparam logic [2:0] INT_LEVEL_RST = 3'h0;
	localparam logic [7:0] INT_VECTOR_RST = 8'h00;
	localparam logic [7:0] BC_BASE_RST = 8'haa;

	localparam int TYPE_LSB = 24;
	localparam int CNT_LSB = 8;
	localparam int CH_LSB = 16;
	localparam logic [2:0] TYPE_HDR = 3'h2;
	localparam logic [2:0] TYPE_DATA = 3'h0;
	localparam logic [2:0] TYPE_EOB = 3'h4;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [15:0] addr;
		logic [15:0] wdata;
	} tdcas_reg_req_t;

	// bit 12 overflow flag, bits 11:0 converted value
	typedef logic [31:0][12:0] tdcas_samples_t;

	typedef struct packed {
		logic start;
		logic stop;
		logic clear;
		logic sample;
	} tdcas_tac_t;

	typedef enum logic [6:0] {
		S_IDLE = 7'h01,
		S_CONV = 7'h02,
		S_SAMPLE = 7'h04,
		S_HEADER = 7'h08,
		S_DATA = 7'h10,
		S_EOB = 7'h20,
		S_CLEAR = 7'h40
	} tdcas_state_t;

	// readout order 0,16,1,17,...,15,31
	function automatic logic [4:0] chan_of(input logic [4:0] slot);
		return {slot[0], slot[4:1]};
	endfunction

	function automatic logic [10:0] evt_base(input logic [4:0] ptr);
		return 11'(ptr * EVT_WORDS);
	endfunction
endpackage

/* src/tdcas_test_fifo.sv */
// circular 32-word fifo holding the injected test event
// assumes set/clear pulses come from writes to the bit set/clear registers
`timescale 1ns/1ns
module tdcas_test_fifo #(
	parameter int DEPTH = tdcas_pkg::FIFO_DEPTH
) (
	input wire logic mclk,
	input wire logic rst,
	input wire logic push,
	input wire logic [15:0] pushData,
	input wire logic pop,
	input wire logic setTest,
	input wire logic clrTest,
	output logic [15:0] popData
);
	localparam int PW = $clog2(DEPTH);
	if (DEPTH != 32) begin : gBadDepth
		$error("test fifo depth must be 32");
	end
	typedef struct packed {
		logic [PW-1:0] wrPtr;
		logic [PW-1:0] rdPtr;
		logic wrHold;
		logic rdHold;
	} tdcas_fifo_st_t;
	tdcas_fifo_st_t st_ff, nxt_st;
	logic [15:0] mem [0:DEPTH-1];

	assign popData = mem[st_ff.rdPtr];

	always_comb begin
		nxt_st = st_ff;
		if (setTest) begin
			nxt_st.wrPtr = '0;
			nxt_st.wrHold = 1'b1;
			nxt_st.rdHold = 1'b0;
		end else if (clrTest) begin
			nxt_st.rdPtr = '0;
			nxt_st.rdHold = 1'b1;
			nxt_st.wrHold = 1'b0;
		end else begin
			// pointers wrap, so extra words overwrite the oldest
			if (push && !st_ff.wrHold) begin
				nxt_st.wrPtr = st_ff.wrPtr + 1'b1;
			end
			if (pop && !st_ff.rdHold) begin
				nxt_st.rdPtr = st_ff.rdPtr + 1'b1;
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			st_ff <= '0;
			st_ff.wrHold <= 1'b1;
			st_ff.rdHold <= 1'b1;
		end else begin
			st_ff <= nxt_st;
		end
	end

	always_ff @(posedge mclk) begin
		if (push && !st_ff.wrHold && !setTest && !clrTest) begin
			mem[st_ff.wrPtr] <= pushData;
		end
	end
endmodule

/* src/tdcas_out_buffer.sv */
// multi-event output buffer, wiped to zero after every reset
// assumes the writer stays off while clearing is high
`timescale 1ns/1ns
module tdcas_out_buffer #(
	parameter int AW = tdcas_pkg::BUF_AW,
	parameter int DEPTH = tdcas_pkg::BUF_DEPTH
) (
	input wire logic mclk,
	input wire logic rst,
	input wire logic we,
	input wire logic [AW-1:0] waddr,
	input wire logic [31:0] wdata,
	input wire logic [AW-1:0] raddr,
	output logic [31:0] rdata,
	output logic clearing
);
	if (DEPTH != (1 << AW)) begin : gBadDepth
		$error("buffer depth must equal 2**AW");
	end
	typedef struct packed {
		logic clearing;
		logic [AW-1:0] clrAddr;
	} tdcas_buf_st_t;
	tdcas_buf_st_t st_ff, nxt_st;
	logic [31:0] mem [0:DEPTH-1];

	assign rdata = mem[raddr];
	assign clearing = st_ff.clearing;

	always_comb begin
		nxt_st = st_ff;
		if (st_ff.clearing) begin
			nxt_st.clrAddr = st_ff.clrAddr + 1'b1;
			if (&st_ff.clrAddr) begin
				nxt_st.clearing = 1'b0;
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			st_ff.clearing <= 1'b1;
			st_ff.clrAddr <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	always_ff @(posedge mclk) begin
		if (st_ff.clearing) begin
			mem[st_ff.clrAddr] <= 32'h0000_0000;
		end else if (we) begin
			mem[waddr] <= wdata;
		end
	end
endmodule

/* src/tdc_acquisition_sequencer.sv */
// acquisition sequencer: trigger handling, filtering, event writing, test modes
// assumes trigger, abort and register requests are synchronous to mclk
`timescale 1ns/1ns
module tdc_acquisition_sequencer #(
	parameter int NUM_CH = tdcas_pkg::NUM_CH,
	parameter int CONV_CYCLES = tdcas_pkg::CONV_CYCLES
) (
	input wire logic mclk,
	input wire logic rst,
	input wire logic convTrig,
	input wire logic abortReq,
	input wire tdcas_pkg::tdcas_reg_req_t regReq,
	input wire tdcas_pkg::tdcas_samples_t chanIn,
	output logic [31:0] regRdata,
	output logic busy,
	output tdcas_pkg::tdcas_tac_t tacCmd
);
	if (NUM_CH != 32 || CONV_CYCLES < 1 || CONV_CYCLES > 256) begin : gBadParam
		$error("sequencer needs 32 channels and 1..256 conversion cycles");
	end

	typedef struct packed {
		tdcas_pkg::tdcas_state_t state;
		logic [7:0] cnt;
		logic [4:0] slot;
		logic [5:0] wIdx;
		logic [5:0] nAcc;
		logic [31:0] accept;
		tdcas_pkg::tdcas_samples_t samples;
		logic busy;
		tdcas_pkg::tdcas_tac_t tac;
		logic [31:0] rdata;
		logic [23:0] evCount;
		logic [4:0] readPtr;
		logic [4:0] writePtr;
		logic [5:0] readIdx;
		logic [15:0] bitSet2;
		logic [2:0] intLevel;
		logic [7:0] intVector;
		logic [7:0] bcBase;
		logic [10:0] wTestAddr;
		logic [10:0] rTestAddr;
		logic [15:0] testHigh;
		logic [31:0][8:0] thr;
	} tdcas_seq_st_t;

	tdcas_seq_st_t st_ff, nxt_st;
	logic bufWe, bufClearing, fifoPush, fifoPop, fifoSet, fifoClr;
	logic trigOk, swComm, memTest, testMode;
	logic [10:0] bufWaddr, bufRaddr;
	logic [31:0] bufWdata, bufRdata, mask;
	logic [15:0] fifoData;
	logic [4:0] ch;

	function automatic logic [31:0] accept_mask(input tdcas_pkg::tdcas_samples_t s,
			input logic [31:0][8:0] t, input logic [15:0] cfg);
		logic [31:0] m;
		m = '0;
		for (int i = 0; i < 32; i++) begin
			m[i] = !t[i][8]
				&& (cfg[tdcas_pkg::BS2_ZERO_DIS] || s[i][11:4] >= t[i][7:0])
				&& (cfg[tdcas_pkg::BS2_OVF_DIS] || !s[i][12]);
		end
		return m;
	endfunction

	function automatic logic [5:0] popcount(input logic [31:0] m);
		logic [5:0] n;
		n = '0;
		for (int i = 0; i < 32; i++) begin
			n = n + {5'h00, m[i]};
		end
		return n;
	endfunction

	function automatic logic meb_full(input logic [4:0] wp, input logic [4:0] rp);
		return (wp + 5'h01) == rp;
	endfunction

	assign memTest = st_ff.bitSet2[tdcas_pkg::BS2_MEMTEST];
	assign testMode = st_ff.bitSet2[tdcas_pkg::BS2_TESTACQ];
	assign swComm = regReq.wr && regReq.addr == tdcas_pkg::ADR_SW_COMM;
	assign trigOk = (convTrig || swComm) && st_ff.state == tdcas_pkg::S_IDLE && !st_ff.busy;
	assign mask = accept_mask(st_ff.samples, st_ff.thr, st_ff.bitSet2);
	assign ch = tdcas_pkg::chan_of(st_ff.slot);
	assign bufRaddr = memTest ? st_ff.rTestAddr
		: tdcas_pkg::evt_base(st_ff.readPtr) + 11'(st_ff.readIdx);

	always_comb begin
		nxt_st = st_ff;
		nxt_st.tac = '0;
		bufWe = 1'b0;
		bufWaddr = tdcas_pkg::evt_base(st_ff.writePtr) + 11'(st_ff.wIdx);
		bufWdata = 32'h0000_0000;
		fifoPush = 1'b0;
		fifoPop = 1'b0;
		fifoSet = 1'b0;
		fifoClr = 1'b0;
		if (regReq.wr) begin
			case (regReq.addr)
				tdcas_pkg::ADR_BS2_SET: begin
					nxt_st.bitSet2 = st_ff.bitSet2 | regReq.wdata;
					fifoSet = regReq.wdata[tdcas_pkg::BS2_TESTACQ];
				end
				tdcas_pkg::ADR_BS2_CLR: begin
					nxt_st.bitSet2 = st_ff.bitSet2 & ~regReq.wdata;
					fifoClr = regReq.wdata[tdcas_pkg::BS2_TESTACQ];
				end
				tdcas_pkg::ADR_INT_LEVEL: nxt_st.intLevel = regReq.wdata[2:0];
				tdcas_pkg::ADR_INT_VECTOR: nxt_st.intVector = regReq.wdata[7:0];
				tdcas_pkg::ADR_BC_BASE: nxt_st.bcBase = regReq.wdata[7:0];
				tdcas_pkg::ADR_W_TEST_ADDR: nxt_st.wTestAddr = regReq.wdata[10:0];
				tdcas_pkg::ADR_R_TEST_ADDR: nxt_st.rTestAddr = regReq.wdata[10:0];
				tdcas_pkg::ADR_TEST_HIGH: nxt_st.testHigh = regReq.wdata;
				tdcas_pkg::ADR_TEST_LOW: begin
					if (memTest) begin
						bufWe = 1'b1;
						bufWaddr = st_ff.wTestAddr;
						bufWdata = {st_ff.testHigh, regReq.wdata};
					end
				end
				tdcas_pkg::ADR_TEST_EVENT: fifoPush = 1'b1;
				tdcas_pkg::ADR_EVC_RESET: nxt_st.evCount = '0;
				tdcas_pkg::ADR_READ_ADV: begin
					if (st_ff.readPtr != st_ff.writePtr) begin
						nxt_st.readPtr = st_ff.readPtr + 5'h01;
					end
					nxt_st.readIdx = '0;
				end
				default: begin
					if ((regReq.addr & tdcas_pkg::ADR_THR_MASK) == tdcas_pkg::ADR_THR_BASE) begin
						nxt_st.thr[regReq.addr[5:1]] = regReq.wdata[8:0];
					end
				end
			endcase
		end
		if (regReq.rd) begin
			case (regReq.addr)
				tdcas_pkg::ADR_BUF_DATA: begin
					nxt_st.rdata = bufRdata;
					if (!memTest) begin
						nxt_st.readIdx = st_ff.readIdx + 6'h01;
					end
				end
				tdcas_pkg::ADR_STATUS: nxt_st.rdata = {28'h000_0000, testMode, bufClearing,
					meb_full(st_ff.writePtr, st_ff.readPtr), st_ff.busy};
				tdcas_pkg::ADR_EVT_COUNT: nxt_st.rdata = {8'h00, st_ff.evCount};
				tdcas_pkg::ADR_BS2_SET: nxt_st.rdata = {16'h0000, st_ff.bitSet2};
				tdcas_pkg::ADR_INT_LEVEL: nxt_st.rdata = {29'h0000_0000, st_ff.intLevel};
				tdcas_pkg::ADR_INT_VECTOR: nxt_st.rdata = {24'h00_0000, st_ff.intVector};
				tdcas_pkg::ADR_BC_BASE: nxt_st.rdata = {24'h00_0000, st_ff.bcBase};
				default: begin
					if ((regReq.addr & tdcas_pkg::ADR_THR_MASK) == tdcas_pkg::ADR_THR_BASE) begin
						nxt_st.rdata = {23'h00_0000, st_ff.thr[regReq.addr[5:1]]};
					end else begin
						nxt_st.rdata = 32'h0000_0000;
					end
				end
			endcase
		end
		case (st_ff.state)
			tdcas_pkg::S_IDLE: begin
				if (trigOk) begin
					if (st_ff.bitSet2[tdcas_pkg::BS2_ALL_TRIG]) begin
						nxt_st.evCount = nxt_st.evCount + 24'h00_0001;
					end
					nxt_st.slot = '0;
					nxt_st.wIdx = '0;
					// sections follow the trigger in test mode too, only their samples go unused
					nxt_st.tac.start = !st_ff.bitSet2[tdcas_pkg::BS2_COMMON_STOP];
					nxt_st.tac.stop = st_ff.bitSet2[tdcas_pkg::BS2_COMMON_STOP];
					if (testMode) begin
						nxt_st.state = tdcas_pkg::S_SAMPLE;
					end else begin
						nxt_st.cnt = 8'(CONV_CYCLES - 1);
						nxt_st.state = tdcas_pkg::S_CONV;
					end
				end
			end
			tdcas_pkg::S_CONV: begin
				if (abortReq) begin
					nxt_st.state = tdcas_pkg::S_CLEAR;
				end else if (st_ff.cnt == 8'h00) begin
					nxt_st.samples = chanIn;
					nxt_st.tac.sample = 1'b1;
					nxt_st.state = tdcas_pkg::S_SAMPLE;
				end else begin
					nxt_st.cnt = st_ff.cnt - 8'h01;
				end
			end
			tdcas_pkg::S_SAMPLE: begin
				if (testMode) begin
					fifoPop = 1'b1;
					nxt_st.samples[ch] = fifoData[12:0];
					nxt_st.slot = st_ff.slot + 5'h01;
					if (&st_ff.slot) begin
						nxt_st.accept = '1;
						nxt_st.nAcc = 6'h20;
						nxt_st.state = tdcas_pkg::S_HEADER;
					end
				end else begin
					nxt_st.accept = mask;
					nxt_st.nAcc = popcount(mask);
					if (mask != '0 || st_ff.bitSet2[tdcas_pkg::BS2_EMPTY_EN]) begin
						nxt_st.state = tdcas_pkg::S_HEADER;
					end else begin
						nxt_st.state = tdcas_pkg::S_CLEAR;
					end
				end
			end
			tdcas_pkg::S_HEADER: begin
				bufWe = 1'b1;
				bufWdata[tdcas_pkg::TYPE_LSB +: 3] = tdcas_pkg::TYPE_HDR;
				bufWdata[tdcas_pkg::CNT_LSB +: 6] = st_ff.nAcc;
				nxt_st.wIdx = 6'h01;
				nxt_st.slot = '0;
				nxt_st.state = tdcas_pkg::S_DATA;
			end
			tdcas_pkg::S_DATA: begin
				if (st_ff.accept[ch]) begin
					bufWe = 1'b1;
					bufWdata[tdcas_pkg::TYPE_LSB +: 3] = tdcas_pkg::TYPE_DATA;
					bufWdata[tdcas_pkg::CH_LSB +: 5] = ch;
					bufWdata[12:0] = st_ff.samples[ch];
					nxt_st.wIdx = st_ff.wIdx + 6'h01;
				end
				nxt_st.slot = st_ff.slot + 5'h01;
				if (&st_ff.slot) begin
					nxt_st.state = tdcas_pkg::S_EOB;
				end
			end
			tdcas_pkg::S_EOB: begin
				bufWe = 1'b1;
				bufWdata[tdcas_pkg::TYPE_LSB +: 3] = tdcas_pkg::TYPE_EOB;
				bufWdata[23:0] = st_ff.evCount;
				nxt_st.writePtr = st_ff.writePtr + 5'h01;
				if (!st_ff.bitSet2[tdcas_pkg::BS2_ALL_TRIG]) begin
					nxt_st.evCount = nxt_st.evCount + 24'h00_0001;
				end
				nxt_st.state = tdcas_pkg::S_CLEAR;
			end
			tdcas_pkg::S_CLEAR: begin
				nxt_st.tac.clear = 1'b1;
				nxt_st.state = tdcas_pkg::S_IDLE;
			end
			default: nxt_st.state = tdcas_pkg::S_IDLE;
		endcase
		nxt_st.busy = nxt_st.state != tdcas_pkg::S_IDLE || bufClearing
			|| meb_full(nxt_st.writePtr, nxt_st.readPtr);
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			st_ff <= '0;
			st_ff.state <= tdcas_pkg::S_IDLE;
			st_ff.busy <= 1'b1;
			st_ff.intLevel <= tdcas_pkg::INT_LEVEL_RST;
			st_ff.intVector <= tdcas_pkg::INT_VECTOR_RST;
			st_ff.bcBase <= tdcas_pkg::BC_BASE_RST;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign regRdata = st_ff.rdata;
	assign busy = st_ff.busy;
	assign tacCmd = st_ff.tac;

	tdcas_out_buffer uBuf (
		.mclk(mclk), .rst(rst), .we(bufWe), .waddr(bufWaddr), .wdata(bufWdata),
		.raddr(bufRaddr), .rdata(bufRdata), .clearing(bufClearing)
	);

	tdcas_test_fifo uFifo (
		.mclk(mclk), .rst(rst), .push(fifoPush), .pushData(regReq.wdata), .pop(fifoPop),
		.setTest(fifoSet), .clrTest(fifoClr), .popData(fifoData)
	);

	sequence s_abortEnd;
		st_ff.state == tdcas_pkg::S_CLEAR ##1 st_ff.state == tdcas_pkg::S_IDLE;
	endsequence
	property p_pwrCount;
		@(posedge mclk) rst |=> st_ff.evCount == 24'h00_0000 && bufClearing;
	endproperty
	a_pwrCount: assert property (p_pwrCount) else $error("count not zero after reset");
	property p_pwrPtr;
		@(posedge mclk) rst |=> st_ff.readPtr == 5'h00 && st_ff.writePtr == 5'h00;
	endproperty
	a_pwrPtr: assert property (p_pwrPtr) else $error("pointers not zero after reset");
	property p_pwrIrq;
		@(posedge mclk) rst |=> st_ff.intLevel == 3'h0 && st_ff.intVector == 8'h00;
	endproperty
	a_pwrIrq: assert property (p_pwrIrq) else $error("interrupt regs not zero");
	property p_pwrBase;
		@(posedge mclk) rst |=> st_ff.bcBase == 8'haa;
	endproperty
	a_pwrBase: assert property (p_pwrBase) else $error("chain base not 0xAA");
	property p_trigBusy;
		@(posedge mclk) disable iff (rst) trigOk |=> busy;
	endproperty
	a_trigBusy: assert property (p_trigBusy) else $error("busy missing after trigger");
	property p_ignore;
		@(posedge mclk) disable iff (rst)
			// the end word may count the stored event in the same cycle
			(convTrig && st_ff.busy && !regReq.wr && st_ff.state != tdcas_pkg::S_EOB)
			|=> st_ff.evCount == $past(st_ff.evCount);
	endproperty
	a_ignore: assert property (p_ignore) else $error("busy trigger changed count");
	property p_abort;
		@(posedge mclk) disable iff (rst)
			(st_ff.state == tdcas_pkg::S_CONV && abortReq) |=> s_abortEnd;
	endproperty
	a_abort: assert property (p_abort) else $error("abort did not cancel");
	property p_clearEnd;
		@(posedge mclk) disable iff (rst)
			st_ff.state == tdcas_pkg::S_CLEAR |=> tacCmd.clear && !(busy && !bufClearing
			&& !meb_full(st_ff.writePtr, st_ff.readPtr));
	endproperty
	a_clearEnd: assert property (p_clearEnd) else $error("end did not clear");
	property p_memTest;
		@(posedge mclk) disable iff (rst)
			(memTest && regReq.wr && regReq.addr == tdcas_pkg::ADR_TEST_LOW
			&& st_ff.state == tdcas_pkg::S_IDLE) |-> bufWe && bufWaddr == st_ff.wTestAddr
			&& bufWdata == {st_ff.testHigh, regReq.wdata};
	endproperty
	a_memTest: assert property (p_memTest) else $error("test word not stored");
	property p_emptySkip;
		@(posedge mclk) disable iff (rst)
			(st_ff.state == tdcas_pkg::S_SAMPLE && !testMode && mask == '0
			&& !st_ff.bitSet2[tdcas_pkg::BS2_EMPTY_EN]) |=> !bufWe ##1 !bufWe;
	endproperty
	a_emptySkip: assert property (p_emptySkip) else $error("empty event written");
endmodule

/* test/tdcas_tac_model.sv */
// behavioural stand-in for the time-to-amplitude sections feeding the sequencer
// assumes the bench sets the converted pattern before each trigger
`timescale 1ns/1ns
module tdcas_tac_model (
	input wire logic mclk,
	input wire logic rst,
	input wire tdcas_pkg::tdcas_tac_t tacCmd,
	input wire tdcas_pkg::tdcas_samples_t pattern,
	output tdcas_pkg::tdcas_samples_t chanIn
);
	logic armed_ff;
	always_ff @(posedge mclk) begin
		if (rst) begin
			armed_ff <= 1'b0;
		end else if (tacCmd.start || tacCmd.stop) begin
			armed_ff <= 1'b1;
		end else if (tacCmd.clear) begin
			armed_ff <= 1'b0;
		end
	end
	// outside a conversion the held levels mean nothing: show the inverse
	assign chanIn = armed_ff ? pattern : ~pattern;
endmodule

/* test/tdc_acquisition_sequencer_tb.sv */
// self-checking bench: register port tasks, trigger runs, buffer readback
// assumes the tac model on chanIn and a shortened conversion count
`timescale 1ns/1ns
module tdc_acquisition_sequencer_tb;
	localparam int CONV = 4;
	logic mclk, rst, convTrig, abortReq, busy;
	tdcas_pkg::tdcas_reg_req_t req;
	tdcas_pkg::tdcas_samples_t pattern, chanIn;
	tdcas_pkg::tdcas_tac_t tacCmd;
	logic [31:0] regRdata, d;
	logic [15:0] tw [32];
	logic [4:0] ch;
	int mismatches, n_tests;

	tdc_acquisition_sequencer #(.CONV_CYCLES(CONV)) uut (.mclk(mclk), .rst(rst),
		.convTrig(convTrig), .abortReq(abortReq), .regReq(req), .chanIn(chanIn),
		.regRdata(regRdata), .busy(busy), .tacCmd(tacCmd));
	tdcas_tac_model tac (.mclk(mclk), .rst(rst), .tacCmd(tacCmd), .pattern(pattern),
		.chanIn(chanIn));

	initial begin
		mclk = 1'b0;
		forever #4 mclk = ~mclk;
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] m);
		n_tests++;
		if ((got & m) !== (exp & m)) begin
			mismatches++;
			$display("[FAIL] t=%0t got %h exp %h", $time, got & m, exp & m);
		end
	endtask

	task automatic wr(input logic [15:0] a, input logic [15:0] v);
		@(posedge mclk);
		req.wr <= 1'b1;
		req.addr <= a;
		req.wdata <= v;
		@(posedge mclk);
		req.wr <= 1'b0;
	endtask

	task automatic rdChk(input logic [15:0] a, input logic [31:0] exp, input logic [31:0] m);
		@(posedge mclk);
		req.rd <= 1'b1;
		req.addr <= a;
		@(posedge mclk);
		req.rd <= 1'b0;
		@(posedge mclk);
		#1 d = regRdata;
		chk(d, exp, m);
	endtask

	task automatic run(input logic stopMode, input logic midTrig, input logic abort,
		input logic timed);
		int n;
		int early;
		n = 0;
		early = 0;
		@(posedge mclk);
		convTrig <= 1'b1;
		@(posedge mclk);
		convTrig <= 1'b0;
		#1 chk({31'h0, busy}, 32'h0000_0001, 32'h0000_0001);
		chk({30'h0, tacCmd.stop, tacCmd.start}, {30'h0, stopMode, !stopMode}, 32'h0000_0003);
		while (tacCmd.sample !== 1'b1 && tacCmd.clear !== 1'b1 && n < 300) begin
			@(posedge mclk);
			convTrig <= midTrig && n == 0;
			abortReq <= abort;
			#1 n++;
		end
		if (timed) chk(n, CONV, 32'hffff_ffff);
		if (abort) chk({31'h0, tacCmd.clear}, 32'h0000_0001, 32'h0000_0001);
		while (tacCmd.clear !== 1'b1 && n < 300) begin
			@(posedge mclk);
			convTrig <= 1'b0;
			#1 n++;
			if (tacCmd.clear !== 1'b1 && busy !== 1'b1) early++;
		end
		chk(early, 0, 32'hffff_ffff);
		chk({31'h0, busy}, 32'h0000_0000, 32'h0000_0001);
		@(posedge mclk);
		abortReq <= 1'b0;
	endtask

	task automatic done(input string s);
		$display("test %s done", s);
	endtask

	task automatic results;
		$display("compares %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	initial begin
		#(8 * 30000);
		mismatches++;
		results;
	end

	initial begin
		rst = 1'b1;
		convTrig = 1'b0;
		abortReq = 1'b0;
		req = '0;
		pattern = '0;
		mismatches = 0;
		n_tests = 0;
		repeat (5) @(posedge mclk);
		rst <= 1'b0;
		for (int i = 0; i < 3000 && busy !== 1'b0; i++) @(posedge mclk);
		rdChk(tdcas_pkg::ADR_EVT_COUNT, 32'h0000_0000, 32'h00ff_ffff);
		rdChk(tdcas_pkg::ADR_BC_BASE, 32'h0000_00aa, 32'h0000_00ff);
		rdChk(tdcas_pkg::ADR_INT_LEVEL, 32'h0000_0000, 32'h0000_0007);
		rdChk(tdcas_pkg::ADR_INT_VECTOR, 32'h0000_0000, 32'h0000_00ff);
		done("reset");
		for (int c = 0; c < 32; c++) begin
			wr(tdcas_pkg::ADR_THR_BASE + 16'(2 * c), c == 1 ? 16'h0100 : c == 2 ? 16'h0080 : 16'h0000);
			pattern[c] = {c == 3, 12'(c * 16 + 3)};
		end
		run(1'b0, 1'b0, 1'b0, 1'b1);
		rdChk(tdcas_pkg::ADR_EVT_COUNT, 32'h0000_0001, 32'h00ff_ffff);
		rdChk(tdcas_pkg::ADR_BUF_DATA, 32'h0200_1d00, 32'h0700_3f00);
		for (int s = 0; s < 32; s++) begin
			ch = 5'((s % 2) * 16 + s / 2);
			if (ch == 0 || ch > 3) rdChk(tdcas_pkg::ADR_BUF_DATA, {11'h0, ch, 4'h0, 12'(ch * 16 + 3)}, 32'h071f_1fff);
		end
		rdChk(tdcas_pkg::ADR_BUF_DATA, 32'h0400_0000, 32'h07ff_ffff);
		wr(tdcas_pkg::ADR_READ_ADV, 16'h0000);
		done("normal");
		run(1'b0, 1'b0, 1'b1, 1'b0);
		rdChk(tdcas_pkg::ADR_EVT_COUNT, 32'h0000_0001, 32'h00ff_ffff);
		done("abort");
		for (int c = 0; c < 32; c++) pattern[c][12] = 1'b1;
		wr(tdcas_pkg::ADR_BS2_SET, 16'h4000);
		run(1'b0, 1'b0, 1'b0, 1'b1);
		wr(tdcas_pkg::ADR_BS2_SET, 16'h1400);
		run(1'b1, 1'b1, 1'b0, 1'b1);
		rdChk(tdcas_pkg::ADR_EVT_COUNT, 32'h0000_0003, 32'h00ff_ffff);
		rdChk(tdcas_pkg::ADR_BUF_DATA, 32'h0200_0000, 32'h0700_3f00);
		rdChk(tdcas_pkg::ADR_BUF_DATA, 32'h0400_0003, 32'h07ff_ffff);
		wr(tdcas_pkg::ADR_READ_ADV, 16'h0000);
		wr(tdcas_pkg::ADR_BS2_CLR, 16'h5400);
		done("empty");
		wr(tdcas_pkg::ADR_BS2_SET, 16'h0040);
		wr(tdcas_pkg::ADR_BS2_CLR, 16'h0040);
		for (int s = 0; s < 32; s++) begin
			tw[s] = 16'((s * 37 + 5) % 4096) | (s == 5 ? 16'h1000 : 16'h0000);
			wr(tdcas_pkg::ADR_TEST_EVENT, tw[s]);
		end
		wr(tdcas_pkg::ADR_BS2_SET, 16'h0040);
		run(1'b0, 1'b0, 1'b0, 1'b0);
		rdChk(tdcas_pkg::ADR_BUF_DATA, 32'h0200_2000, 32'h0700_3f00);
		for (int s = 0; s < 32; s++) begin
			rdChk(tdcas_pkg::ADR_BUF_DATA, {19'h0, tw[s][12:0]}, 32'h0700_1fff);
		end
		rdChk(tdcas_pkg::ADR_BUF_DATA, 32'h0400_0000, 32'h0700_0000);
		wr(tdcas_pkg::ADR_READ_ADV, 16'h0000);
		wr(tdcas_pkg::ADR_BS2_CLR, 16'h0040);
		done("acq test");
		wr(tdcas_pkg::ADR_BS2_SET, 16'h0001);
		wr(tdcas_pkg::ADR_W_TEST_ADDR, 16'h07fe);
		wr(tdcas_pkg::ADR_TEST_HIGH, 16'hbeef);
		wr(tdcas_pkg::ADR_TEST_LOW, 16'h1234);
		wr(tdcas_pkg::ADR_W_TEST_ADDR, 16'h07fd);
		wr(tdcas_pkg::ADR_R_TEST_ADDR, 16'h07fe);
		rdChk(tdcas_pkg::ADR_BUF_DATA, 32'hbeef_1234, 32'hffff_ffff);
		wr(tdcas_pkg::ADR_R_TEST_ADDR, 16'h07ff);
		rdChk(tdcas_pkg::ADR_BUF_DATA, 32'h0000_0000, 32'hffff_ffff);
		done("random access");
		results;
	end
endmodule
